// [hdl/lpc_pkg.sv]
// Purpose: shared constants and types for the low-power and module stop control block
// Assumes: 8-bit registers, one per aligned 32-bit word on AXI4-Lite
// Notes: offsets are chosen locally; no printed offsets exist
package lpc_pkg;
    // register byte offsets
    localparam logic [3:0] OFS_LOW_POWER = 4'h0;
    localparam logic [3:0] OFS_STOP_A = 4'h4;
    localparam logic [3:0] OFS_STOP_B = 4'h8;
    localparam logic [3:0] OFS_MODE = 4'hC;
    // reset values
    localparam logic [7:0] RST_LOW_POWER = 8'h00;
    localparam logic [7:0] RST_STOP_A = 8'h3F;
    localparam logic [7:0] RST_STOP_B = 8'hFF;
    // low power control field positions
    localparam int BIT_DIRECT = 7;
    localparam int BIT_LOW_SPEED = 6;
    localparam int BIT_NOISE_SEL = 5;
    localparam int BIT_SUB_DISABLE = 4;
    localparam int BIT_FB_CUT = 3;
    localparam int BIT_MULT_HI = 1;
    localparam int BIT_MULT_LO = 0;
    // stop register A positions
    localparam int BIT_STOP_XFER = 6;
    localparam int BIT_STOP_PTU = 5;
    localparam int BIT_STOP_PGEN = 3;
    localparam int BIT_STOP_DAC = 2;
    localparam int BIT_STOP_ADC = 1;
    // stop register B positions
    localparam int BIT_STOP_SER0 = 7;
    localparam int BIT_STOP_SER1 = 6;
    localparam int BIT_STOP_SER2 = 5;
    localparam int BIT_STOP_TW0 = 4;
    localparam int BIT_STOP_TW1 = 3;
    // subclock sampling divisors
    localparam logic [4:0] DIV_SLOW_LAST = 5'h1F; // phi/32
    localparam logic [4:0] DIV_FAST_LAST = 5'h03; // phi/4
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // mode after sleep
    typedef enum logic [2:0] {
        MODE_SLEEP,
        MODE_SOFT_STANDBY,
        MODE_WATCH,
        MODE_SUBACTIVE,
        MODE_SUBSLEEP,
        MODE_DIRECT_HIGH,
        MODE_DIRECT_SUB,
        MODE_INVALID
    } sleep_mode_t;

    // bus slave and register state
    typedef struct packed {
        logic [7:0] low_power;
        logic [7:0] stop_a;
        logic [7:0] stop_b;
        logic aw_held;
        logic [3:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } regs_t;
endpackage

// [hdl/subclock_sampler.sv]
// Purpose: samples the subclock with a divided system clock strobe
// Assumes: subclock arrives from a pin, asynchronous to aclk
// Notes: divisor picked by the noise select bit
`timescale 1ns/1ps
`default_nettype none
module subclock_sampler (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic fast_sample,
    input wire logic enable,
    // subclock
    input wire logic subclock_in,
    output logic subclock_sampled
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic [4:0] count;
        logic sampled;
    } samp_t;
    samp_t s_reg, s_next;
    logic [4:0] last;

    // divide phi by 32 or 4 and sample at the wrap
    always_comb begin
        s_next = s_reg;
        last = fast_sample ? lpc_pkg::DIV_FAST_LAST : lpc_pkg::DIV_SLOW_LAST; // [R2]
        s_next.sync1 = subclock_in;
        s_next.sync2 = s_reg.sync1;
        if (s_reg.count >= last) begin
            s_next.count = 5'h0_0;
            s_next.sampled = s_reg.sync2 & enable; // held low while disabled
        end else begin
            s_next.count = s_reg.count + 5'h0_1;
        end
        // drop at once on disable; waiting for the wrap would leave a stale high
        if (!enable) begin
            s_next.sampled = 1'b0; // [R4]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign subclock_sampled = s_reg.sampled;
endmodule
`default_nettype wire

// [hdl/low_power_ctrl.sv]
// Purpose: low-power control and module stop registers behind AXI4-Lite
// Assumes: one clock aclk, synchronous active-low reset
// Notes: registers are 8 bits in the low byte of each word
// How it works
// (R1) direct and low-speed flags pick post-sleep mode
// (R2) sample subclock at phi/32 or phi/4
// (R3) software keeps noise select 0 above 5 MHz
// (R4) subclock disable bit 1 stops subclock
// (R5) feedback resistor on only while oscillating, unless cut
// (R6) software writes reserved bit 2 as zero
// (R7) multiplier field gives x1, x2, x4
// (R8) software never writes multiplier 11
// (R9) stop bit one stops module, zero releases
// (R10) register A bits gate five listed peripherals
// (R11) register B bits gate serial and two-wire ports
// (R12) software writes fixed values to unassigned stop bits
// (R13) reset restores initial values, reads return writes
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module low_power_ctrl (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // mode inputs from standby and watchdog control; main clock status for the resistor
    input wire logic standby_select,
    input wire logic watchdog_prescaler_select,
    input wire logic main_clock_running,
    // subclock
    input wire logic subclock_in,
    output logic subclock_sampled,
    output logic subclock_enable,
    // oscillator, pll and post-sleep mode
    output logic feedback_resistor_on,
    output logic [2:0] pll_factor,
    output logic [2:0] sleep_mode,
    // module stop outputs
    output logic stop_transfer_controller,
    output logic stop_pulse_timer_unit,
    output logic stop_pulse_generator,
    output logic stop_dac,
    output logic stop_adc,
    output logic stop_serial_0,
    output logic stop_serial_1,
    output logic stop_serial_2,
    output logic stop_twowire_0,
    output logic stop_twowire_1
);
    lpc_pkg::regs_t r_reg, r_next;
    lpc_pkg::sleep_mode_t mode;
    logic wr_fire;
    logic [7:0] rd_val;
    logic rd_hit;
    logic [7:0] lp;

    // byte-lane merge of the low byte
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                         input logic [3:0] strb);
        merge = strb[0] ? nw : old;
    endfunction

    // register read decode
    function automatic logic [8:0] read_reg(input logic [3:0] a, input lpc_pkg::regs_t r,
                                            input logic [2:0] m);
        if (a == lpc_pkg::OFS_LOW_POWER) begin
            read_reg = {1'b1, r.low_power};
        end else if (a == lpc_pkg::OFS_STOP_A) begin
            read_reg = {1'b1, r.stop_a};
        end else if (a == lpc_pkg::OFS_STOP_B) begin
            read_reg = {1'b1, r.stop_b};
        end else if (a == lpc_pkg::OFS_MODE) begin
            read_reg = {1'b1, 5'h0_0, m};
        end else begin
            read_reg = 9'h0_00;
        end
    endfunction

    assign lp = r_reg.low_power;

    // post-sleep mode selection
    always_comb begin
        mode = lpc_pkg::MODE_INVALID;
        case ({standby_select, watchdog_prescaler_select, lp[lpc_pkg::BIT_LOW_SPEED],
               lp[lpc_pkg::BIT_DIRECT]}) // [R1]
            4'b0000: mode = lpc_pkg::MODE_SLEEP;
            4'b0001: mode = lpc_pkg::MODE_SLEEP;
            4'b1000: mode = lpc_pkg::MODE_SOFT_STANDBY;
            4'b1001: mode = lpc_pkg::MODE_SOFT_STANDBY;
            4'b1100: mode = lpc_pkg::MODE_WATCH;
            4'b1101: mode = lpc_pkg::MODE_DIRECT_HIGH;
            4'b1110: mode = lpc_pkg::MODE_WATCH;
            4'b1111: mode = lpc_pkg::MODE_DIRECT_SUB;
            4'b0110: mode = lpc_pkg::MODE_SUBSLEEP;
            4'b0111: mode = lpc_pkg::MODE_SUBSLEEP;
            default: mode = lpc_pkg::MODE_INVALID;
        endcase
    end

    assign wr_fire = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
    assign {rd_hit, rd_val} = read_reg(s_axi_araddr[3:0], r_reg, mode);

    // bus slave and register updates
    always_comb begin
        r_next = r_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            r_next.aw_held = 1'b1;
            r_next.aw_addr = s_axi_awaddr[3:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_next.w_held = 1'b1;
            r_next.w_data = s_axi_wdata[7:0];
            r_next.w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            r_next.aw_held = 1'b0;
            r_next.w_held = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = lpc_pkg::RESP_OKAY;
            // all bits stored as written, reserved bit included [R13]
            if (r_reg.aw_addr == lpc_pkg::OFS_LOW_POWER) begin
                r_next.low_power = merge(r_reg.low_power, r_reg.w_data, r_reg.w_strb);
            end else if (r_reg.aw_addr == lpc_pkg::OFS_STOP_A) begin
                r_next.stop_a = merge(r_reg.stop_a, r_reg.w_data, r_reg.w_strb); // [R9]
            end else if (r_reg.aw_addr == lpc_pkg::OFS_STOP_B) begin
                r_next.stop_b = merge(r_reg.stop_b, r_reg.w_data, r_reg.w_strb); // [R9]
            end else if (r_reg.aw_addr == lpc_pkg::OFS_MODE) begin
                r_next.bresp = lpc_pkg::RESP_OKAY; // read-only, write ignored
            end else begin
                r_next.bresp = lpc_pkg::RESP_SLVERR;
            end
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            r_next.rvalid = 1'b1;
            r_next.rdata = {24'h00_0000, rd_val};
            r_next.rresp = rd_hit ? lpc_pkg::RESP_OKAY : lpc_pkg::RESP_SLVERR;
        end else if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
    end

    // reset loads documented initial values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            r_reg.low_power <= lpc_pkg::RST_LOW_POWER; // [R13]
            r_reg.stop_a <= lpc_pkg::RST_STOP_A; // [R13]
            r_reg.stop_b <= lpc_pkg::RST_STOP_B; // [R13]
        end else begin
            r_reg <= r_next;
        end
    end

    // handshake outputs; one outstanding address and data each
    assign s_axi_awready = !r_reg.aw_held;
    assign s_axi_wready = !r_reg.w_held;
    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_arready = !r_reg.rvalid;
    assign s_axi_rvalid = r_reg.rvalid;
    assign s_axi_rdata = r_reg.rdata;
    assign s_axi_rresp = r_reg.rresp;

    // subclock sampler; sampling off while subclock disabled
    subclock_sampler u_sampler (
        .aclk(aclk),
        .aresetn(aresetn),
        .fast_sample(lp[lpc_pkg::BIT_NOISE_SEL]), // [R2]
        .enable(subclock_enable),
        .subclock_in(subclock_in),
        .subclock_sampled(subclock_sampled)
    );

    assign subclock_enable = !lp[lpc_pkg::BIT_SUB_DISABLE]; // [R4]
    // resistor only helps while the crystal actually swings
    assign feedback_resistor_on = !lp[lpc_pkg::BIT_FB_CUT] && main_clock_running; // [R5]

    // multiplier decode; 11 is prohibited and falls back to x1
    always_comb begin
        case ({lp[lpc_pkg::BIT_MULT_HI], lp[lpc_pkg::BIT_MULT_LO]}) // [R7]
            2'b01: pll_factor = 3'h2;
            2'b10: pll_factor = 3'h4;
            default: pll_factor = 3'h1;
        endcase
    end

    assign sleep_mode = mode;

    // module stop gating
    assign stop_transfer_controller = r_reg.stop_a[lpc_pkg::BIT_STOP_XFER]; // [R10]
    assign stop_pulse_timer_unit = r_reg.stop_a[lpc_pkg::BIT_STOP_PTU]; // [R10]
    assign stop_pulse_generator = r_reg.stop_a[lpc_pkg::BIT_STOP_PGEN]; // [R10]
    assign stop_dac = r_reg.stop_a[lpc_pkg::BIT_STOP_DAC]; // [R10]
    assign stop_adc = r_reg.stop_a[lpc_pkg::BIT_STOP_ADC]; // [R10]
    assign stop_serial_0 = r_reg.stop_b[lpc_pkg::BIT_STOP_SER0]; // [R11]
    assign stop_serial_1 = r_reg.stop_b[lpc_pkg::BIT_STOP_SER1]; // [R11]
    assign stop_serial_2 = r_reg.stop_b[lpc_pkg::BIT_STOP_SER2]; // [R11]
    assign stop_twowire_0 = r_reg.stop_b[lpc_pkg::BIT_STOP_TW0]; // [R11]
    assign stop_twowire_1 = r_reg.stop_b[lpc_pkg::BIT_STOP_TW1]; // [R11]
endmodule
`default_nettype wire

// [verif/lpc_asserts.sv]
// Purpose: port-level checks for the low power and module stop block
// Assumes: one clock aclk, synchronous active-low reset
// Notes: register contents are seen only through the decoded outputs
`timescale 1ns/1ps
`default_nettype none
module lpc_asserts (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // controls
    input wire logic main_clock_running,
    input wire logic feedback_resistor_on,
    input wire logic [2:0] pll_factor,
    input wire logic subclock_enable,
    input wire logic subclock_sampled,
    input wire logic stop_adc,
    input wire logic stop_serial_0
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // both write halves taken at one edge
    wire both_in = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // resistor may only be on while the oscillator runs
    fb_needs_clock_a: assert property (feedback_resistor_on |-> main_clock_running)
        else $error("feedback resistor on while main clock stopped");
    pll_legal_a: assert property (pll_factor inside {3'h1, 3'h2, 3'h4})
        else $error("pll factor outside one two four");
    write_answer_a: assert property (both_in |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    sub_quiet_a: assert property (!subclock_enable [*3] |-> !subclock_sampled)
        else $error("sampled subclock active while disabled");
    // outputs straight from registers move only with a write answer
    ctrl_on_write_a: assert property (!$stable({pll_factor, subclock_enable, stop_adc,
        stop_serial_0}) |-> $rose(s_axi_bvalid))
        else $error("control output moved without a write");
    write_seen_c: cover property (both_in);
    read_seen_c: cover property (s_axi_rvalid && s_axi_rready);
    sub_rise_c: cover property (subclock_enable && $rose(subclock_sampled));
endmodule
bind low_power_ctrl lpc_asserts u_chk (.*);
`default_nettype wire

// [verif/tb.sv]
// Purpose: self-checking bench for the low power and module stop block
// Assumes: 50 MHz aclk; bus tasks look at readies on the falling edge
// Notes: noise select stays 0 at this clock, so only the slow rate runs
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
    logic [31:0] s_axi_araddr = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, subclock_in = 1'b0, s;
    logic standby_select = 1'b0, watchdog_prescaler_select = 1'b0, main_clock_running = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic subclock_sampled, subclock_enable, feedback_resistor_on;
    logic [2:0] pll_factor, sleep_mode;
    logic stop_transfer_controller, stop_pulse_timer_unit, stop_pulse_generator, stop_dac;
    logic stop_adc, stop_serial_0, stop_serial_1, stop_serial_2, stop_twowire_0, stop_twowire_1;
    logic [7:0] a, b, v;
    logic [7:0] pats [4] = '{8'h55, 8'hAA, 8'h00, 8'hFF};
    // standby_select, pss, low_speed_flag, direct_transition_flag, then expected mode code
    logic [6:0] modes [6] = '{7'h00, 7'h41, 7'h34, 7'h62, 7'h6D, 7'h7E};
    int bad_count = 0, compares = 0, n;

    low_power_ctrl uut (.*);

    initial forever #10 aclk = ~aclk;

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ready raised late on purpose so the slave must hold its answer
    task automatic wr(input logic [3:0] ad, input logic [7:0] d, input logic [3:0] st);
        logic aw_ok, w_ok, b_ok;
        @(posedge aclk);
        s_axi_awaddr <= {28'h000_0000, ad};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        b_ok = 1'b0;
        for (int i = 0; i < 40 && !b_ok; i++) begin
            @(negedge aclk);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            b_ok = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
            s_axi_bready <= (i >= 3) && !b_ok;
        end
        if (!b_ok) bad_count++; // no write answer within the limit
    endtask

    task automatic rdr(input logic [3:0] ad);
        logic ar_ok, r_ok;
        @(posedge aclk);
        s_axi_araddr <= {28'h000_0000, ad};
        s_axi_arvalid <= 1'b1;
        r_ok = 1'b0;
        for (int i = 0; i < 40 && !r_ok; i++) begin
            @(negedge aclk);
            ar_ok = s_axi_arvalid && s_axi_arready;
            r_ok = s_axi_rvalid && s_axi_rready;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
            s_axi_rready <= (i >= 3) && !r_ok;
        end
        if (!r_ok) bad_count++; // no read answer within the limit
    endtask

    task automatic rchk(input logic [3:0] ad, input logic [7:0] exp);
        rdr(ad);
        check_val(rd, {24'h00_0000, exp});
        check_val(resp, lpc_pkg::RESP_OKAY);
    endtask

    task automatic check_stops(input logic [7:0] sa, input logic [7:0] sb);
        check_val({stop_transfer_controller, stop_pulse_timer_unit}, sa[6:5]);
        check_val({stop_pulse_generator, stop_dac, stop_adc}, sa[3:1]);
        check_val({stop_serial_0, stop_serial_1, stop_serial_2}, sb[7:5]);
        check_val({stop_twowire_0, stop_twowire_1}, sb[4:3]);
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    task automatic final_report();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        do_reset();
        rchk(4'h0, lpc_pkg::RST_LOW_POWER);
        rchk(4'h4, lpc_pkg::RST_STOP_A);
        rchk(4'h8, lpc_pkg::RST_STOP_B);
        check_stops(lpc_pkg::RST_STOP_A, lpc_pkg::RST_STOP_B);
        // unassigned stop bits kept at their fixed values
        foreach (pats[i]) begin
            a = (pats[i] & 8'h6E) | 8'h11;
            b = (~pats[i] & 8'hF8) | 8'h07;
            wr(4'h4, a, 4'h1);
            wr(4'h8, b, 4'h1);
            rchk(4'h4, a);
            rchk(4'h8, b);
            check_stops(a, b);
        end
        // reserved bit and fast sampling never set multiplier never 11
        for (int i = 0; i < 8; i++) begin
            if (i == 2 || i == 5) continue;
            v = 8'h01 << i;
            wr(4'h0, v, 4'h1);
            rchk(4'h0, v);
            check_val(subclock_enable, !v[4]);
            check_val(pll_factor, v[1] ? 3'h4 : (v[0] ? 3'h2 : 3'h1));
            check_val(feedback_resistor_on, !v[3]);
            main_clock_running <= 1'b0;
            @(negedge aclk);
            check_val(feedback_resistor_on, 1'b0);
            @(posedge aclk);
            main_clock_running <= 1'b1;
        end
        wr(4'h0, 8'h01, 4'hE);
        rchk(4'h0, 8'h80);
        foreach (modes[i]) begin
            {standby_select, watchdog_prescaler_select} <= modes[i][6:5];
            wr(4'h0, {modes[i][3], modes[i][4], 6'h00}, 4'h1);
            rchk(4'hC, {5'h00, modes[i][2:0]});
            check_val(sleep_mode, modes[i][2:0]);
        end
        rdr(4'h1);
        check_val(resp, lpc_pkg::RESP_SLVERR);
        check_val(rd, 32'h0000_0000);
        wr(4'h5, 8'h00, 4'h1);
        check_val(resp, lpc_pkg::RESP_SLVERR);
        wr(4'hC, 8'h00, 4'h1);
        check_val(resp, lpc_pkg::RESP_OKAY);
        rchk(4'h4, a);
        // input toggling every 8 cycles: slow sampling sees few changes
        wr(4'h0, 8'h00, 4'h1);
        n = 0;
        s = subclock_sampled;
        for (int k = 0; k < 256; k++) begin
            @(posedge aclk);
            subclock_in <= k[3];
            @(negedge aclk);
            if (subclock_sampled !== s) n++;
            s = subclock_sampled;
        end
        check_val(n <= 10, 1'b1);
        @(posedge aclk);
        subclock_in <= 1'b1;
        for (n = 0; n < 40 && subclock_sampled !== 1'b1; n++) @(negedge aclk);
        check_val(subclock_sampled, 1'b1);
        wr(4'h0, 8'h10, 4'h1);
        repeat (40) @(negedge aclk);
        check_val(subclock_sampled, 1'b0);
        @(posedge aclk);
        do_reset();
        rchk(4'h4, lpc_pkg::RST_STOP_A);
        rchk(4'h0, lpc_pkg::RST_LOW_POWER);
        final_report();
    end

    // hang guard, several times the expected run length
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
